// *** rtl/mgmt_port_pkg.sv ***
// Constants, field layout and state encoding of the management port
// control register.
// Assumes a single core clock and a synchronous, active-low reset.
package mgmt_port_pkg;

  // ---------------------------------------------------------------------
  // Register placement
  // ---------------------------------------------------------------------
  localparam logic [11:0] MGMT_CTRL_OFFSET = 12'h354;
  localparam int MGMT_CTRL_MIN_ADDR_W = 12;

  // ---------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------
  localparam int ACT_PORT_HI_BIT = 4;
  localparam int ACT_PORT_LO_MSB = 2;
  localparam int TIED_LOW_BIT = 3;
  localparam int NT_ENABLE_BIT = 5;
  localparam int RELOAD_SCOPE_BIT = 6;
  localparam int RED_PORT_HI_BIT = 12;
  localparam int RED_PORT_LO_MSB = 10;
  localparam int RED_PORT_LO_LSB = 8;
  localparam int RED_ENABLE_BIT = 13;

  // Bits that hold state; everything else reads as zero.
  localparam logic [31:0] MGMT_CTRL_WRITE_MASK = 32'h0000_3777;

  // ---------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------
  localparam logic [3:0] RED_PORT_RESET = 4'h0;
  localparam logic RED_ENABLE_RESET = 1'b0;
  localparam logic RELOAD_SCOPE_RESET = 1'b0;
  localparam logic [1:0] VS_MODE_BASE = 2'h0;

  // ---------------------------------------------------------------------
  // Port number encoding
  // ---------------------------------------------------------------------
  localparam logic [3:0] FIELD_LOW_LAST = 4'h3;
  localparam logic [3:0] FIELD_LAST = 4'hb;
  localparam logic [4:0] FIELD_HIGH_FIRST = 5'h04;
  localparam logic [4:0] PORT_HIGH_BASE = 5'h10;

  // ---------------------------------------------------------------------
  // Control sequence
  // ---------------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IN_RESET = 2'b00,
    ST_CAPTURE = 2'b01,
    ST_RUN = 2'b11
  } ctrl_state_t;

  // Port field sits split around the tied-low bit: {bit 4, bits 2:0}.
  function automatic logic [3:0] act_field(input logic [31:0] r);
    act_field = {r[ACT_PORT_HI_BIT], r[ACT_PORT_LO_MSB:0]};
  endfunction : act_field

  function automatic logic [3:0] red_field(input logic [31:0] r);
    red_field = {r[RED_PORT_HI_BIT], r[RED_PORT_LO_MSB:RED_PORT_LO_LSB]};
  endfunction : red_field

endpackage : mgmt_port_pkg

// *** rtl/port_number_decode.sv ***
// Decoder from a four-bit management port field to a switch port number.
// Purely combinational; the caller registers the result.
`timescale 1ns/1ps
module port_number_decode
  import mgmt_port_pkg::*;
(
  input wire logic [3:0] field_in,
  output logic [4:0] port_out,
  output logic valid_out
);

  // ---------------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------------
  always_comb begin
    if (field_in <= FIELD_LOW_LAST) begin
      port_out = {1'b0, field_in};
      valid_out = 1'b1;
    end else if (field_in <= FIELD_LAST) begin
      // Upper station ports start at 16 and run up to 23.  // see R3
      port_out = 5'(PORT_HIGH_BASE + {1'b0, field_in} - FIELD_HIGH_FIRST);
      valid_out = 1'b1;
    end else begin
      // Reserved encodings name no port.  // see R3
      port_out = 5'h00;
      valid_out = 1'b0;
    end
  end

endmodule : port_number_decode

// *** rtl/strap_capture.sv ***
// Catches the strap levels on the first clock edge after reset release.
// Assumes straps are stable and synchronous to the core clock.
`timescale 1ns/1ps
module strap_capture (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [3:0] upstream_port_select_straps_in,
  input wire logic nontransparent_enable_strap_n_in,
  input wire logic [1:0] virtual_switch_mode_straps_in,
  output logic capture_out,
  output logic [3:0] upstream_out,
  output logic nt_strap_n_out,
  output logic [1:0] vs_mode_out
);

  typedef struct packed {
    logic was_reset;
    logic capture;
    logic [3:0] upstream;
    logic nt_n;
    logic [1:0] vs_mode;
  } strap_state_t;

  strap_state_t st;
  strap_state_t next_st;

  // ---------------------------------------------------------------------
  // Capture at release
  // ---------------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.capture = 1'b0;
    if (!rst_n_in) begin
      next_st = '0;
      next_st.was_reset = 1'b1;
    end else if (st.was_reset) begin
      // Sampled only after release, so reset itself stays constant.
      next_st.was_reset = 1'b0;
      next_st.capture = 1'b1;
      next_st.upstream = upstream_port_select_straps_in; // see R1
      next_st.nt_n = nontransparent_enable_strap_n_in; // see R5
      next_st.vs_mode = virtual_switch_mode_straps_in; // see R13
    end
  end

  always_ff @(posedge clk_in) begin
    st <= next_st;
  end

  assign capture_out = st.capture;
  assign upstream_out = st.upstream;
  assign nt_strap_n_out = st.nt_n;
  assign vs_mode_out = st.vs_mode;

endmodule : strap_capture

// *** rtl/mgmt_port_control_regs.sv ***
// Management port control register of the switch in virtual switch mode,
// with its in-band and loader access ports and the reload trigger.
// Assumes the ingress logic tags each in-band access with its port number
// and that loaders (serial EEPROM, I2C) present plain register writes.
`timescale 1ns/1ps
//
// Overview of operation
// R1: At reset release, catch upstream select straps into active port field.
// R2: Field bits 4,2 from straps 3:2 pick station; bits 1:0 pick port.
// R3: Field 4h..Bh decode to ports 16..23; unlisted codes are reserved.
// R4: Bit 3 is tied low; writers must keep it zero.
// R5: Bit 5 enables non-transparent mode; loads inverted low-active strap.
// R6: Hot reset or link down on management port starts EEPROM reload.
// R7: Bit 6 clear (default) reloads only management port registers.
// R8: Bit 6 set also reloads chip and station registers.
// R9: Bits 12,10:8 hold redundant port, reset 0h, 0..3 and 16..23.
// R10: Bit 13 enables redundant port, zero after reset.
// R11: Reserved bits read zero; writes to them change nothing.
// R12: Register at 354h reachable via active and redundant ports.
// R13: Register exists only when virtual switch mode straps are non-zero.
// R14: Writers should place only listed encodings in port fields.
module mgmt_port_control_regs
  import mgmt_port_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input wire logic SYS_CLK_IN,
  input wire logic RST_N_IN,
  input wire logic [3:0] UPSTREAM_PORT_SELECT_STRAPS_IN,
  input wire logic NONTRANSPARENT_ENABLE_STRAP_N_IN,
  input wire logic [1:0] VIRTUAL_SWITCH_MODE_STRAPS_IN,
  input wire logic CFG_REQ_IN,
  input wire logic CFG_WRITE_IN,
  input wire logic [4:0] CFG_PORT_IN,
  input wire logic [ADDR_W-1:0] CFG_ADDR_IN,
  input wire logic [3:0] CFG_BE_IN,
  input wire logic [31:0] CFG_WDATA_IN,
  output logic CFG_ACK_OUT,
  output logic CFG_ERR_OUT,
  output logic [31:0] CFG_RDATA_OUT,
  input wire logic LOAD_REQ_IN,
  input wire logic LOAD_WRITE_IN,
  input wire logic [ADDR_W-1:0] LOAD_ADDR_IN,
  input wire logic [3:0] LOAD_BE_IN,
  input wire logic [31:0] LOAD_WDATA_IN,
  output logic LOAD_ACK_OUT,
  output logic [31:0] LOAD_RDATA_OUT,
  input wire logic MGMT_HOT_RESET_IN,
  input wire logic MGMT_DL_DOWN_IN,
  output logic RELOAD_REQ_OUT,
  output logic RELOAD_CHIP_OUT,
  output logic RELOAD_STATION_OUT,
  output logic RELOAD_PORT_OUT,
  output logic [1:0] RELOAD_STATION_NUM_OUT,
  output logic [4:0] RELOAD_PORT_NUM_OUT,
  output logic VIRTUAL_SWITCH_MODE_OUT,
  output logic [4:0] ACTIVE_MGMT_PORT_OUT,
  output logic ACTIVE_MGMT_VALID_OUT,
  output logic NT_ENABLE_OUT,
  output logic [4:0] REDUNDANT_MGMT_PORT_OUT,
  output logic REDUNDANT_MGMT_VALID_OUT,
  output logic REDUNDANT_MGMT_ENABLE_OUT,
  output logic [31:0] MGMT_CTRL_OUT
);

  // ---------------------------------------------------------------------
  // Elaboration check
  // ---------------------------------------------------------------------
  if (ADDR_W < MGMT_CTRL_MIN_ADDR_W) begin : g_addr_check
    $error("ADDR_W too narrow for the register offset.");
  end

  // ---------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------
  typedef struct packed {
    ctrl_state_t fsm;
    logic [31:0] ctrl;
    logic vs_mode;
    logic [4:0] act_port;
    logic act_valid;
    logic [4:0] red_port;
    logic red_valid;
    logic cfg_ack;
    logic cfg_err;
    logic [31:0] cfg_rdata;
    logic load_ack;
    logic [31:0] load_rdata;
    logic link_prev;
    logic reload_req;
    logic reload_chip;
    logic reload_station;
    logic reload_port;
    logic [1:0] reload_station_num;
    logic [4:0] reload_port_num;
  } regs_state_t;

  regs_state_t st;
  regs_state_t next_st;

  logic strap_capture;
  logic [3:0] strap_upstream;
  logic strap_nt_n;
  logic [1:0] virtual_switch_mode_straps;
  logic [3:0] dec_field [2];
  logic [4:0] dec_port [2];
  logic dec_valid [2];

  // ---------------------------------------------------------------------
  // Strap capture and port decoders
  // ---------------------------------------------------------------------
  strap_capture u_strap_capture (
    .clk_in(SYS_CLK_IN),
    .rst_n_in(RST_N_IN),
    .upstream_port_select_straps_in(UPSTREAM_PORT_SELECT_STRAPS_IN),
    .nontransparent_enable_strap_n_in(NONTRANSPARENT_ENABLE_STRAP_N_IN),
    .virtual_switch_mode_straps_in(VIRTUAL_SWITCH_MODE_STRAPS_IN),
    .capture_out(strap_capture),
    .upstream_out(strap_upstream),
    .nt_strap_n_out(strap_nt_n),
    .vs_mode_out(virtual_switch_mode_straps)
  );

  assign dec_field[0] = act_field(st.ctrl);
  assign dec_field[1] = red_field(st.ctrl);

  for (genvar i = 0; i < 2; i++) begin : g_decode
    port_number_decode u_decode (
      .field_in(dec_field[i]),
      .port_out(dec_port[i]),
      .valid_out(dec_valid[i])
    );
  end

  // ---------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------
  function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
    addr_hit = ({a[ADDR_W-1:2], 2'b00} == ADDR_W'(MGMT_CTRL_OFFSET));
  endfunction : addr_hit

  // Byte-lane merge, then only the stored bits survive; bit 3 and the
  // reserved bits never take a written one.
  function automatic logic [31:0] merge_write(
    input logic [31:0] cur,
    input logic [31:0] wdata,
    input logic [3:0] be
  );
    logic [31:0] merged;
    merged = cur;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        merged[8*b +: 8] = wdata[8*b +: 8];
      end
    end
    merge_write = merged & MGMT_CTRL_WRITE_MASK; // see R4, R11
  endfunction : merge_write

  // ---------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------
  always_comb begin
    logic running;
    logic cfg_allowed;
    logic trig;
    running = 1'b0;
    cfg_allowed = 1'b0;
    trig = 1'b0;
    next_st = st;
    next_st.cfg_ack = 1'b0;
    next_st.cfg_err = 1'b0;
    next_st.cfg_rdata = 32'h0000_0000;
    next_st.load_ack = 1'b0;
    next_st.load_rdata = 32'h0000_0000;
    next_st.reload_req = 1'b0;
    // Decoded ports lag the register by one cycle; the extra state
    // before running lets them settle before access checks use them.
    next_st.act_port = dec_port[0];
    next_st.act_valid = dec_valid[0];
    next_st.red_port = dec_port[1];
    next_st.red_valid = dec_valid[1];
    running = (st.fsm == ST_RUN);
    trig = MGMT_HOT_RESET_IN | MGMT_DL_DOWN_IN;
    next_st.link_prev = trig;

    // The in-band request must come in through a management port.
    cfg_allowed = st.vs_mode &&
                  ((st.act_valid && CFG_PORT_IN == st.act_port) ||
                   (st.ctrl[RED_ENABLE_BIT] && st.red_valid &&
                    CFG_PORT_IN == st.red_port)); // see R12

    case (st.fsm)
      ST_IN_RESET: begin
        if (strap_capture) begin
          next_st.fsm = ST_CAPTURE;
          next_st.vs_mode = (virtual_switch_mode_straps != VS_MODE_BASE); // see R13
          next_st.ctrl = 32'h0000_0000;
          next_st.ctrl[ACT_PORT_HI_BIT] = strap_upstream[3]; // see R1, R2
          next_st.ctrl[ACT_PORT_LO_MSB] = strap_upstream[2]; // see R2
          next_st.ctrl[1:0] = strap_upstream[1:0]; // see R2
          next_st.ctrl[TIED_LOW_BIT] = 1'b0; // see R4
          next_st.ctrl[NT_ENABLE_BIT] = ~strap_nt_n; // see R5
          next_st.ctrl[RELOAD_SCOPE_BIT] = RELOAD_SCOPE_RESET; // see R7
          next_st.ctrl[RED_PORT_HI_BIT] = RED_PORT_RESET[3]; // see R9
          next_st.ctrl[RED_PORT_LO_MSB:RED_PORT_LO_LSB] =
            RED_PORT_RESET[2:0]; // see R9
          next_st.ctrl[RED_ENABLE_BIT] = RED_ENABLE_RESET; // see R10
        end
      end
      ST_CAPTURE: begin
        next_st.fsm = ST_RUN;
      end
      ST_RUN: begin
        next_st.fsm = ST_RUN;
      end
      default: begin
        next_st.fsm = ST_IN_RESET;
      end
    endcase

    // In-band access; refused before running or from a foreign port.
    if (CFG_REQ_IN) begin
      next_st.cfg_ack = 1'b1;
      if (!running || !cfg_allowed) begin
        next_st.cfg_err = 1'b1;
      end else if (addr_hit(CFG_ADDR_IN)) begin
        if (CFG_WRITE_IN) begin
          next_st.ctrl = merge_write(next_st.ctrl, CFG_WDATA_IN, CFG_BE_IN);
        end else begin
          next_st.cfg_rdata = st.ctrl & MGMT_CTRL_WRITE_MASK; // see R11
        end
      end
    end

    // Loader access; applied after in-band so the loader wins a clash.
    if (LOAD_REQ_IN) begin
      next_st.load_ack = 1'b1;
      if (running && st.vs_mode && addr_hit(LOAD_ADDR_IN)) begin // see R13
        if (LOAD_WRITE_IN) begin
          next_st.ctrl = merge_write(next_st.ctrl, LOAD_WDATA_IN, LOAD_BE_IN);
        end else begin
          next_st.load_rdata = st.ctrl & MGMT_CTRL_WRITE_MASK; // see R11
        end
      end
    end

    // Reload on the rising edge of hot reset or link down.
    if (running && st.vs_mode && trig && !st.link_prev) begin // see R6
      next_st.reload_req = 1'b1;
      next_st.reload_port = 1'b1; // see R7
      next_st.reload_chip = st.ctrl[RELOAD_SCOPE_BIT]; // see R8
      next_st.reload_station = st.ctrl[RELOAD_SCOPE_BIT]; // see R8
      next_st.reload_station_num =
        {st.ctrl[ACT_PORT_HI_BIT], st.ctrl[ACT_PORT_LO_MSB]}; // see R8
      next_st.reload_port_num = st.act_port; // see R6
    end

    if (!RST_N_IN) begin
      next_st = '0;
      next_st.fsm = ST_IN_RESET;
    end
  end

  always_ff @(posedge SYS_CLK_IN) begin
    st <= next_st;
  end

  // ---------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------
  assign CFG_ACK_OUT = st.cfg_ack;
  assign CFG_ERR_OUT = st.cfg_err;
  assign CFG_RDATA_OUT = st.cfg_rdata;
  assign LOAD_ACK_OUT = st.load_ack;
  assign LOAD_RDATA_OUT = st.load_rdata;
  assign RELOAD_REQ_OUT = st.reload_req;
  assign RELOAD_CHIP_OUT = st.reload_chip;
  assign RELOAD_STATION_OUT = st.reload_station;
  assign RELOAD_PORT_OUT = st.reload_port;
  assign RELOAD_STATION_NUM_OUT = st.reload_station_num;
  assign RELOAD_PORT_NUM_OUT = st.reload_port_num;
  assign VIRTUAL_SWITCH_MODE_OUT = st.vs_mode;
  assign ACTIVE_MGMT_PORT_OUT = st.act_port;
  assign ACTIVE_MGMT_VALID_OUT = st.act_valid;
  assign NT_ENABLE_OUT = st.ctrl[NT_ENABLE_BIT];
  assign REDUNDANT_MGMT_PORT_OUT = st.red_port;
  assign REDUNDANT_MGMT_VALID_OUT = st.red_valid;
  assign REDUNDANT_MGMT_ENABLE_OUT = st.ctrl[RED_ENABLE_BIT];
  assign MGMT_CTRL_OUT = st.ctrl;

endmodule : mgmt_port_control_regs

// *** tb/mgmt_port_control_regs_sva.sv ***
// Checker for the management port control register, ports only.
// Assumes it is bound to the top module; one clock, synchronous reset.
`timescale 1ns/1ps
module mgmt_port_control_regs_sva (
  input wire logic SYS_CLK_IN,
  input wire logic RST_N_IN,
  input wire logic [3:0] UPSTREAM_PORT_SELECT_STRAPS_IN,
  input wire logic NONTRANSPARENT_ENABLE_STRAP_N_IN,
  input wire logic CFG_REQ_IN,
  input wire logic [4:0] CFG_PORT_IN,
  input wire logic CFG_ACK_OUT,
  input wire logic CFG_ERR_OUT,
  input wire logic [31:0] CFG_RDATA_OUT,
  input wire logic MGMT_HOT_RESET_IN,
  input wire logic MGMT_DL_DOWN_IN,
  input wire logic RELOAD_REQ_OUT,
  input wire logic RELOAD_CHIP_OUT,
  input wire logic RELOAD_STATION_OUT,
  input wire logic RELOAD_PORT_OUT,
  input wire logic [1:0] RELOAD_STATION_NUM_OUT,
  input wire logic [4:0] RELOAD_PORT_NUM_OUT,
  input wire logic VIRTUAL_SWITCH_MODE_OUT,
  input wire logic [4:0] ACTIVE_MGMT_PORT_OUT,
  input wire logic ACTIVE_MGMT_VALID_OUT,
  input wire logic NT_ENABLE_OUT,
  input wire logic [4:0] REDUNDANT_MGMT_PORT_OUT,
  input wire logic REDUNDANT_MGMT_VALID_OUT,
  input wire logic REDUNDANT_MGMT_ENABLE_OUT,
  input wire logic [31:0] MGMT_CTRL_OUT
);
  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  // The counter gates checks until the decoded ports have settled.
  logic [1:0] up;
  logic lvl, ok;
  logic [3:0] af, rf;
  assign lvl = MGMT_HOT_RESET_IN | MGMT_DL_DOWN_IN;
  assign af = {MGMT_CTRL_OUT[4], MGMT_CTRL_OUT[2:0]};
  assign rf = {MGMT_CTRL_OUT[12], MGMT_CTRL_OUT[10:8]};
  assign ok = (ACTIVE_MGMT_VALID_OUT && CFG_PORT_IN == ACTIVE_MGMT_PORT_OUT)
    || (REDUNDANT_MGMT_ENABLE_OUT && REDUNDANT_MGMT_VALID_OUT
    && CFG_PORT_IN == REDUNDANT_MGMT_PORT_OUT);
  always_ff @(posedge SYS_CLK_IN) begin
    if (!RST_N_IN) up <= 2'h0;
    else if (up != 2'h3) up <= up + 2'h1;
  end
  function automatic logic [5:0] dec(input logic [3:0] f);
    dec = f < 4'h4 ? {2'h2, f} : f < 4'hc ? {1'b1, 5'(f) + 5'h0c} : 6'h00;
  endfunction : dec
  // ------------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------------
  default clocking cb @(posedge SYS_CLK_IN);
  endclocking
  default disable iff (!RST_N_IN);
  sequence s_rise;
    !lvl ##1 lvl;
  endsequence
  sequence s_pulse;
    RELOAD_REQ_OUT ##1 !RELOAD_REQ_OUT;
  endsequence
  AST_ACK: assert property (CFG_REQ_IN |=> CFG_ACK_OUT)
    else $error("request not acknowledged one cycle later");
  AST_GATE: assert property (CFG_REQ_IN && VIRTUAL_SWITCH_MODE_OUT &&
    up == 2'h3 |=> CFG_ERR_OUT == !$past(ok)) else $error("port gate wrong");
  AST_NO_VS: assert property (CFG_REQ_IN && !VIRTUAL_SWITCH_MODE_OUT
    |=> CFG_ERR_OUT && CFG_RDATA_OUT == 32'h0) else $error("no refusal");
  AST_RSVD: assert property ((MGMT_CTRL_OUT & 32'hffff_c888) == 32'h0)
    else $error("reserved or tied bit set");
  AST_STRAP: assert property (up == 2'h2 && VIRTUAL_SWITCH_MODE_OUT |->
    af == $past(UPSTREAM_PORT_SELECT_STRAPS_IN, 2)
    && MGMT_CTRL_OUT[5] == !$past(NONTRANSPARENT_ENABLE_STRAP_N_IN, 2)
    && (MGMT_CTRL_OUT & 32'h3740) == 32'h0) else $error("bad reset value");
  AST_MIRROR: assert property (NT_ENABLE_OUT == MGMT_CTRL_OUT[5]
    && REDUNDANT_MGMT_ENABLE_OUT == MGMT_CTRL_OUT[13])
    else $error("enable outputs differ from register");
  AST_ACT_DEC: assert property (up == 2'h3 |->
    {ACTIVE_MGMT_VALID_OUT, ACTIVE_MGMT_PORT_OUT} == dec($past(af)))
    else $error("active port decode wrong");
  AST_RED_DEC: assert property (up == 2'h3 |->
    {REDUNDANT_MGMT_VALID_OUT, REDUNDANT_MGMT_PORT_OUT} == dec($past(rf)))
    else $error("redundant port decode wrong");
  AST_FIRE: assert property (s_rise ##0 up == 2'h3 &&
    VIRTUAL_SWITCH_MODE_OUT |=> RELOAD_REQ_OUT) else $error("no reload");
  AST_CAUSE: assert property (RELOAD_REQ_OUT |-> $past(lvl) &&
    !$past(lvl, 2) && VIRTUAL_SWITCH_MODE_OUT) else $error("stray reload");
  AST_SCOPE: assert property (RELOAD_REQ_OUT |->
    RELOAD_CHIP_OUT == $past(MGMT_CTRL_OUT[6]) && RELOAD_PORT_OUT
    && RELOAD_STATION_OUT == RELOAD_CHIP_OUT
    && RELOAD_STATION_NUM_OUT == $past(af[3:2])
    && RELOAD_PORT_NUM_OUT == $past(ACTIVE_MGMT_PORT_OUT))
    else $error("reload scope wrong");
  COV_PULSE: cover property (s_pulse);
endmodule : mgmt_port_control_regs_sva

bind mgmt_port_control_regs mgmt_port_control_regs_sva u_sva (.*);

// *** tb/tb_mgmt_port_control_regs.sv ***
// Self-checking bench for the management port control register.
// Assumes a 10 MHz core clock; both buses share write data lines.
`timescale 1ns/1ps
module tb_mgmt_port_control_regs;
  // ------------------------------------------------------------------
  // Stimulus, reference copy of the register and result queues
  // ------------------------------------------------------------------
  logic clk, rst_n, nt_n, creq, wr, lreq, hot, dl, cack, cerr, lack;
  logic rreq, rchip, vs_on;
  logic [1:0] vs, k;
  logic [3:0] straps, be, maf, mrf;
  logic [4:0] port, rpnum;
  logic [5:0] t;
  logic [11:0] addr;
  logic [31:0] wd, crd, lrd, model, d;
  logic [32:0] ex;
  logic [32:0] cq[$];
  logic [31:0] lq[$];
  int fail_count, samples_checked, pulses, i, seed;
  assign maf = {model[4], model[2:0]};
  assign mrf = {model[12], model[10:8]};

  mgmt_port_control_regs dut (
    .SYS_CLK_IN(clk),
    .RST_N_IN(rst_n),
    .UPSTREAM_PORT_SELECT_STRAPS_IN(straps),
    .NONTRANSPARENT_ENABLE_STRAP_N_IN(nt_n),
    .VIRTUAL_SWITCH_MODE_STRAPS_IN(vs),
    .CFG_REQ_IN(creq),
    .CFG_WRITE_IN(wr),
    .CFG_PORT_IN(port),
    .CFG_ADDR_IN(addr),
    .CFG_BE_IN(be),
    .CFG_WDATA_IN(wd),
    .CFG_ACK_OUT(cack),
    .CFG_ERR_OUT(cerr),
    .CFG_RDATA_OUT(crd),
    .LOAD_REQ_IN(lreq),
    .LOAD_WRITE_IN(wr),
    .LOAD_ADDR_IN(addr),
    .LOAD_BE_IN(be),
    .LOAD_WDATA_IN(wd),
    .LOAD_ACK_OUT(lack),
    .LOAD_RDATA_OUT(lrd),
    .MGMT_HOT_RESET_IN(hot),
    .MGMT_DL_DOWN_IN(dl),
    .RELOAD_REQ_OUT(rreq),
    .RELOAD_CHIP_OUT(rchip),
    .RELOAD_STATION_OUT(),
    .RELOAD_PORT_OUT(),
    .RELOAD_STATION_NUM_OUT(),
    .RELOAD_PORT_NUM_OUT(rpnum),
    .VIRTUAL_SWITCH_MODE_OUT(),
    .ACTIVE_MGMT_PORT_OUT(),
    .ACTIVE_MGMT_VALID_OUT(),
    .NT_ENABLE_OUT(),
    .REDUNDANT_MGMT_PORT_OUT(),
    .REDUNDANT_MGMT_VALID_OUT(),
    .REDUNDANT_MGMT_ENABLE_OUT(),
    .MGMT_CTRL_OUT()
  );

  function automatic logic [5:0] dec(input logic [3:0] f);
    dec = f < 4'h4 ? {2'h2, f} : f < 4'hc ? {1'b1, 5'(f) + 5'h0c} : 6'h00;
  endfunction : dec

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Accesses are spaced two cycles apart, so the decoded ports used by
  // the port check always reflect the previous write.
  task automatic acc(input logic ld, input logic w, input logic [4:0] p,
      input logic [11:0] a, input logic [3:0] b, input logic [31:0] v);
    logic [5:0] ta, tr;
    logic [31:0] m;
    logic hit, e;
    ta = dec(maf);
    tr = dec(mrf);
    hit = a == 12'h354 && vs_on;
    e = !ld && (!vs_on || !((ta[5] && p == ta[4:0])
      || (model[13] && tr[5] && p == tr[4:0])));
    m = {{8{b[3]}}, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}} & 32'h0000_3777;
    if (ld) lq.push_back(hit && !w ? model : 32'h0);
    else cq.push_back({e, hit && !w && !e ? model : 32'h0});
    if (hit && w && !e) model = (model & ~m) | (v & m);
    @(posedge clk);
    creq <= !ld;
    lreq <= ld;
    wr <= w;
    port <= p;
    addr <= a;
    be <= b;
    wd <= v;
    @(posedge clk);
    creq <= 1'b0;
    lreq <= 1'b0;
  endtask : acc

  task automatic do_reset(input logic [1:0] v);
    logic [3:0] s;
    logic n;
    s = 4'($unsigned($random(seed)) % 12);
    n = 1'($random(seed));
    rst_n <= 1'b0;
    vs <= v;
    straps <= s;
    nt_n <= n;
    vs_on = v != 2'h0;
    model = vs_on ? {26'h0, !n, s[3], 1'b0, s[2:0]} : 32'h0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
  endtask : do_reset

  // The level is held for several cycles; only one pulse may follow.
  task automatic reload(input logic src);
    int n;
    logic [5:0] ta;
    n = pulses;
    ta = dec(maf);
    @(posedge clk);
    hot <= src;
    dl <= !src;
    repeat (5) @(posedge clk);
    hot <= 1'b0;
    dl <= 1'b0;
    @(posedge clk);
    chk(32'(pulses - n), {31'h0, vs_on});
    chk({31'h0, rchip}, {31'h0, model[6] & vs_on});
    chk({27'h0, rpnum}, {27'h0, vs_on ? ta[4:0] : 5'h0});
  endtask : reload

  task automatic report_and_stop;
    // A note still queued means its acknowledge never came.
    if (cq.size() != 0 || lq.size() != 0) fail_count++;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : report_and_stop

  always @(posedge clk) begin
    if (rreq === 1'b1) pulses++;
    if (lack === 1'b1) chk(lrd, lq.pop_front());
    if (cack === 1'b1) begin
      ex = cq.pop_front();
      chk({31'h0, cerr}, {31'h0, ex[32]});
      chk(crd, ex[31:0]);
    end
  end

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  initial begin
    repeat (3000) @(posedge clk);
    fail_count++;
    report_and_stop();
  end

  initial begin
    seed = 32'he1b2;
    {rst_n, creq, lreq, wr, hot, dl} = 6'h0;
    {port, addr, be, wd} = 53'h0;
    do_reset(2'h3);
    acc(1'b1, 1'b0, 5'h0, 12'h354, 4'hf, 32'h0);
    $display("reset value test done");
    for (i = 0; i < 60; i++) begin
      k = 2'($unsigned($random(seed)) % 3);
      d = $random(seed);
      t = dec(k == 2'h0 ? maf : k == 2'h1 ? mrf : d[3:0]);
      d[3] = 1'b0;
      {d[4], d[2:0]} = 4'($unsigned($random(seed)) % 12);
      {d[12], d[10:8]} = 4'($unsigned($random(seed)) % 12);
      acc(d[31], d[30], t[4:0], d[29:27] == 3'h0 ? 12'h350 : 12'h354,
        d[26:23], d);
    end
    $display("random access test done");
    for (i = 0; i < 4; i++) begin
      acc(1'b1, 1'b1, 5'h0, 12'h354, 4'h1, {model[31:7], i[1], model[5:0]});
      reload(i[0]);
    end
    $display("reload test done");
    do_reset(2'h0);
    acc(1'b0, 1'b0, 5'h0, 12'h354, 4'hf, 32'h0);
    acc(1'b1, 1'b1, 5'h0, 12'h354, 4'hf, 32'h2000);
    acc(1'b1, 1'b0, 5'h0, 12'h354, 4'hf, 32'h0);
    reload(1'b1);
    do_reset(2'h1);
    t = dec(maf);
    acc(1'b0, 1'b0, t[4:0], 12'h354, 4'hf, 32'h0);
    acc(1'b1, 1'b1, 5'h0, 12'h354, 4'h2, 32'h3100);
    acc(1'b0, 1'b0, 5'h15, 12'h354, 4'hf, 32'h0);
    $display("mode strap test done");
    repeat (3) @(posedge clk);
    report_and_stop();
  end
endmodule : tb_mgmt_port_control_regs
